// ---- logic/stp_timers.sv ----
// Purpose: three 16-bit timers, second and third pair to 32 bits
// Assumes: APB slave, zero wait, pins pass a two-stage synchroniser
// Notes: async mode on the first timer samples through the same
// Notes: two flops; with sync off the count path is unchanged, bit 2 is unused
`timescale 1ns/1ps
module stp_timers (
    input wire logic clk_i, // 10 MHz clock
    input wire logic rst_i, // sync reset, high
    input wire logic ce_i, // clock enable
    input wire logic idle_i, // device in idle mode
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic first_ext_clock_pin_i, // first ext clock
    input wire logic second_ext_clock_pin_i, // second ext clock
    input wire logic third_ext_clock_pin_i, // third ext clock
    input wire logic first_gate_i, // first gate pin
    input wire logic second_gate_i, // second gate pin
    input wire logic third_gate_i, // third gate pin
    output logic first_irq_o, // first flag pulse
    output logic second_irq_o, // second flag pulse
    output logic third_irq_o, // third flag pulse
    output logic adc_trigger_o, // converter trigger
    output logic [15:0] capture_base2_o, // second count
    output logic [15:0] capture_base3_o, // third count
    output stp_pkg::stp_evt_t events_o // flag bundle
);
    import stp_pkg::*;

    logic [15:0] con1_ff, con2_ff, con3_ff;
    logic [15:0] cnt1_ff, cnt2_ff, cnt3_ff;
    logic [15:0] per1_ff, per2_ff, per3_ff;
    logic [2:0] flag_ff;
    logic [2:0] s1_ff, s2_ff;
    logic [2:0] pin_ff, pin_d_ff;
    logic [2:0] g1_ff, g2_ff, gate_d_ff;
    logic [7:0] ps1_ff, ps2_ff, ps3_ff;
    logic first_irq_ff, second_irq_ff, third_irq_ff, adc_ff;
    stp_ctl_t c1, c2, c3;
    logic wide;
    logic [2:0] edge_rise, gate_lvl, gate_fall;
    logic src1, src2, src3, tk1, tk2, tk3;
    logic m1, m2, m3, m32;
    logic wr, rd;
    logic [2:0] gf;

    // unpack a control word into its fields
    function automatic stp_ctl_t unpack(input logic [15:0] w);
        stp_ctl_t c;
        c.run_bit = w[BIT_RUN];
        c.idle_halt = w[BIT_IDLE];
        c.gate_accumulate = w[BIT_GATE];
        c.prescale_select = w[BIT_PS_LO+1:BIT_PS_LO];
        c.pair_wide_mode = w[BIT_WIDE];
        c.ext_clock_sync = w[BIT_SYNC];
        c.clock_source_select = w[BIT_CS];
        return c;
    endfunction

    // prescaler terminal count for a select code
    function automatic logic [7:0] ps_top(input logic [1:0] s);
        case (s)
            2'h1: ps_top = PS_DIV8;
            2'h2: ps_top = PS_DIV64;
            2'h3: ps_top = PS_DIV256;
            default: ps_top = 8'h00;
        endcase
    endfunction

    // enabled and not halted by idle
    function automatic logic live(input stp_ctl_t c);
        live = c.run_bit && !(c.idle_halt && idle_i);
    endfunction

    // count source: pin edge, or clock, or gated clock
    function automatic logic src(input stp_ctl_t c, input logic e,
                                 input logic g);
        if (c.clock_source_select)
            src = e;
        else if (c.gate_accumulate)
            src = g;
        else
            src = 1'b1;
    endfunction

    assign c1 = unpack(con1_ff);
    assign c2 = unpack(con2_ff);
    assign c3 = unpack(con3_ff);
    assign wide = c2.pair_wide_mode;

    // pin synchronisers, second stage only is read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= 3'h0;
            s2_ff <= 3'h0;
            g1_ff <= 3'h0;
            g2_ff <= 3'h0;
        end else if (ce_i) begin
            s1_ff <= {third_ext_clock_pin_i, second_ext_clock_pin_i,
                      first_ext_clock_pin_i};
            s2_ff <= s1_ff;
            g1_ff <= {third_gate_i, second_gate_i, first_gate_i};
            g2_ff <= g1_ff;
        end
    end

    // edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_d_ff <= 3'h0;
            gate_d_ff <= 3'h0;
        end else if (ce_i) begin
            pin_d_ff <= s2_ff;
            gate_d_ff <= g2_ff;
        end
    end

    assign pin_ff = s2_ff;
    assign edge_rise = pin_ff & ~pin_d_ff;
    assign gate_lvl = g2_ff;
    assign gate_fall = gate_d_ff & ~g2_ff;

    // first timer also counts pin edges with sync off
    assign src1 = src(c1, edge_rise[0], gate_lvl[0]);
    // paired uses second timer's source and gate
    assign src2 = src(c2, edge_rise[1], gate_lvl[1]);
    assign src3 = src(c3, edge_rise[2], gate_lvl[2]);

    // prescalers ahead of the counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ps1_ff <= 8'h00;
            ps2_ff <= 8'h00;
            ps3_ff <= 8'h00;
        end else if (ce_i) begin
            if (!c1.run_bit)
                ps1_ff <= 8'h00;
            else if (live(c1) && src1)
                ps1_ff <= tk1 ? 8'h00 : ps1_ff + 8'h01;
            if (!c2.run_bit)
                ps2_ff <= 8'h00;
            else if (live(c2) && src2)
                ps2_ff <= tk2 ? 8'h00 : ps2_ff + 8'h01;
            if (!c3.run_bit)
                ps3_ff <= 8'h00;
            else if (live(c3) && src3)
                ps3_ff <= tk3 ? 8'h00 : ps3_ff + 8'h01;
        end
    end

    assign tk1 = live(c1) && src1 &&
                 (ps1_ff == ps_top(c1.prescale_select));
    assign tk2 = live(c2) && src2 &&
                 (ps2_ff == ps_top(c2.prescale_select));
    assign tk3 = !wide && live(c3) && src3 &&
                 (ps3_ff == ps_top(c3.prescale_select));

    assign m1 = (cnt1_ff == per1_ff);
    assign m2 = (cnt2_ff == per2_ff);
    assign m3 = (cnt3_ff == per3_ff);
    assign m32 = m2 && m3;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    // counters; a bus write to a count wins over counting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt1_ff <= 16'h0000;
            cnt2_ff <= 16'h0000;
            cnt3_ff <= 16'h0000;
        end else if (ce_i) begin
            if (wr && paddr[7:0] == OFS_CNT1)
                cnt1_ff <= pwdata[15:0];
            else if (tk1)
                cnt1_ff <= m1 ? 16'h0000 : cnt1_ff + 16'h0001;
            if (wr && paddr[7:0] == OFS_CNT2)
                cnt2_ff <= pwdata[15:0];
            else if (tk2)
                cnt2_ff <= (m2 && (!wide || m3)) ? 16'h0000 :
                           cnt2_ff + 16'h0001;
            if (wr && paddr[7:0] == OFS_CNT3)
                cnt3_ff <= pwdata[15:0];
            else if (wide && tk2 && m32)
                cnt3_ff <= 16'h0000;
            else if (wide && tk2 && cnt2_ff == 16'hffff)
                cnt3_ff <= cnt3_ff + 16'h0001;
            else if (tk3)
                cnt3_ff <= m3 ? 16'h0000 : cnt3_ff + 16'h0001;
        end
    end

    // control and period registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            con1_ff <= CON_RESET;
            con2_ff <= CON_RESET;
            con3_ff <= CON_RESET;
            per1_ff <= PER_RESET;
            per2_ff <= PER_RESET;
            per3_ff <= PER_RESET;
        end else if (ce_i && wr) begin
            case (paddr[7:0])
                OFS_CON1: con1_ff <= pwdata[15:0] & CON1_MASK;
                OFS_CON2: con2_ff <= pwdata[15:0] & CON2_MASK;
                OFS_CON3: con3_ff <= pwdata[15:0] & CON3_MASK;
                OFS_PER1: per1_ff <= pwdata[15:0];
                OFS_PER2: per2_ff <= pwdata[15:0];
                OFS_PER3: per3_ff <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // event sources per timer
    assign gf[0] = (tk1 && m1) || (c1.run_bit && !c1.clock_source_select
                   && c1.gate_accumulate && gate_fall[0]);
    assign gf[1] = !wide && ((tk2 && m2) || (c2.run_bit &&
                   !c2.clock_source_select && c2.gate_accumulate &&
                   gate_fall[1]));
    assign gf[2] = wide ? ((tk2 && m32) || (c2.run_bit &&
                   !c2.clock_source_select && c2.gate_accumulate &&
                   gate_fall[1])) :
                   ((tk3 && m3) || (c3.run_bit &&
                   !c3.clock_source_select && c3.gate_accumulate &&
                   gate_fall[2]));

    // sticky flags, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i)
            flag_ff <= 3'h0;
        else if (ce_i)
            flag_ff <= (flag_ff & ~((wr && paddr[7:0] == OFS_FLAG) ?
                        pwdata[2:0] : 3'h0)) | gf;
    end

    // registered event pulses and converter trigger
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_irq_ff <= 1'b0;
            second_irq_ff <= 1'b0;
            third_irq_ff <= 1'b0;
            adc_ff <= 1'b0;
        end else if (ce_i) begin
            first_irq_ff <= gf[0];
            second_irq_ff <= gf[1];
            third_irq_ff <= gf[2];
            adc_ff <= wide && tk2 && m32;
        end else begin
            first_irq_ff <= 1'b0;
            second_irq_ff <= 1'b0;
            third_irq_ff <= 1'b0;
            adc_ff <= 1'b0;
        end
    end

    assign first_irq_o = first_irq_ff;
    assign second_irq_o = second_irq_ff;
    assign third_irq_o = third_irq_ff;
    assign adc_trigger_o = adc_ff;
    assign capture_base2_o = cnt2_ff;
    assign capture_base3_o = cnt3_ff;
    assign events_o = '{tick1: first_irq_ff, tick2: second_irq_ff,
                        tick3: third_irq_ff};

    // apb read mux, zero wait
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (rd) begin
            case (paddr[7:0])
                OFS_CON1: prdata[15:0] = con1_ff;
                OFS_CNT1: prdata[15:0] = cnt1_ff;
                OFS_PER1: prdata[15:0] = per1_ff;
                OFS_CON2: prdata[15:0] = con2_ff;
                OFS_CNT2: prdata[15:0] = cnt2_ff;
                OFS_PER2: prdata[15:0] = per2_ff;
                OFS_CON3: prdata[15:0] = con3_ff;
                OFS_CNT3: prdata[15:0] = cnt3_ff;
                OFS_PER3: prdata[15:0] = per3_ff;
                OFS_FLAG: prdata[2:0] = flag_ff;
                default: pslverr = 1'b1;
            endcase
        end else if (psel && penable && paddr[7:0] > OFS_FLAG) begin
            pslverr = 1'b1;
        end
    end

    assign pready = 1'b1;
endmodule

// ---- logic/stp_pkg.sv ----
// Purpose: constants and types for the three-timer block
// Assumes: APB slave, 10 MHz clk_i, 32-bit data, 16-bit registers
// Notes: offsets are byte addresses; upper data bits read zero
// Notes on behaviour
// - first timer: timer, sync and async counter; async here still counts through the synchroniser
// - first timer interrupt on match or gate fall
// - bit 15 runs or stops each timer
// - bit 13 halts the timer in idle
// - bit 6 gates accumulation, internal clock only
// - bits 5-4 prescale 1, 8, 64, 256
// - bit 2 syncs first external clock; bit 2 is unused here, the pin is always synchronised
// - bit 1 picks external pin or internal
// - second, third timers: no async counter mode
// - pair makes 32-bit timer or sync counter
// - second timer low word, third high word
// - paired: third control ignored, flag third
// - 32-bit period in two period registers
// - count pair reads third high, second low
// - second timer bit 3 joins the pair
// - only paired timer makes converter trigger
// - second and third counts feed capture/compare
// - timers run in idle unless bit 13 is set, and in sleep
// - unimplemented control bits read zero
package stp_pkg;
    localparam logic [7:0] OFS_CON1 = 8'h00;
    localparam logic [7:0] OFS_CNT1 = 8'h04;
    localparam logic [7:0] OFS_PER1 = 8'h08;
    localparam logic [7:0] OFS_CON2 = 8'h0c;
    localparam logic [7:0] OFS_CNT2 = 8'h10;
    localparam logic [7:0] OFS_PER2 = 8'h14;
    localparam logic [7:0] OFS_CON3 = 8'h18;
    localparam logic [7:0] OFS_CNT3 = 8'h1c;
    localparam logic [7:0] OFS_PER3 = 8'h20;
    localparam logic [7:0] OFS_FLAG = 8'h24;
    localparam int BIT_RUN = 15;
    localparam int BIT_IDLE = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_WIDE = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_CS = 1;
    localparam logic [15:0] CON1_MASK = 16'ha076;
    localparam logic [15:0] CON2_MASK = 16'ha07a;
    localparam logic [15:0] CON3_MASK = 16'ha072;
    localparam logic [15:0] CON_RESET = 16'h0000;
    localparam logic [15:0] PER_RESET = 16'hffff;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3f;
    localparam logic [7:0] PS_DIV256 = 8'hff;
    typedef struct packed {
        logic run_bit;
        logic idle_halt;
        logic gate_accumulate;
        logic [1:0] prescale_select;
        logic pair_wide_mode;
        logic ext_clock_sync;
        logic clock_source_select;
    } stp_ctl_t;
    typedef struct packed {
        logic tick1;
        logic tick2;
        logic tick3;
    } stp_evt_t;
endpackage

// ---- tb/stp_pin_model.sv ----
// Purpose: far-side model of an external timer clock pin
// Assumes: pin toggles every half_i+1 clocks while enabled
// Notes: the pin rests low between bursts, never runs free
`timescale 1ns/1ps
module stp_pin_model (
    input wire logic clk_i, // bench clock
    input wire logic en_i, // burst enable
    input wire logic [3:0] half_i, // half period less one
    output logic pin_o // clock pin
);
    logic [3:0] cnt_ff;
    // toggle while enabled, hold low otherwise
    always_ff @(posedge clk_i) begin
        if (!en_i) begin
            cnt_ff <= 4'h0;
            pin_o <= 1'b0;
        end else if (cnt_ff >= half_i) begin
            cnt_ff <= 4'h0;
            pin_o <= ~pin_o; // each rise is one count
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule

// ---- tb/stp_timers_assertions.sv ----
// Purpose: port checks for the three-timer block
// Assumes: zero-wait apb, one clock domain
// Notes: bound to every timer block instance
`timescale 1ns/1ps
module stp_chk (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [31:0] paddr, // address
    input wire logic [31:0] prdata, // read data
    input wire logic second_irq_o, // second pulse
    input wire logic third_irq_o, // third pulse
    input wire logic first_irq_o, // first pulse
    input wire logic adc_trigger_o, // trigger
    input wire logic [15:0] capture_base2_o, // low count
    input wire logic [15:0] capture_base3_o, // high count
    input stp_pkg::stp_evt_t events_o // pulse bundle
);
    import stp_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd;
    logic wr;
    // read and write access phases
    assign rd = psel && penable && !pwrite;
    assign wr = psel && penable && pwrite;
    con1_bits_a: assert property (rd && paddr[7:0] == OFS_CON1
        |-> prdata == (prdata & {16'h0, CON1_MASK}))
        else $error("first control spare bit set");
    con2_bits_a: assert property (rd && paddr[7:0] == OFS_CON2
        |-> prdata == (prdata & {16'h0, CON2_MASK}))
        else $error("second control spare bit set");
    con3_bits_a: assert property (rd && paddr[7:0] == OFS_CON3
        |-> prdata == (prdata & {16'h0, CON3_MASK}))
        else $error("third control spare bit set");
    low_read_a: assert property (rd && paddr[7:0] == OFS_CNT2
        |-> prdata == {16'h0, capture_base2_o})
        else $error("low count read mismatch");
    high_read_a: assert property (rd && paddr[7:0] == OFS_CNT3
        |-> prdata == {16'h0, capture_base3_o})
        else $error("high count read mismatch");
    pulse_bundle_a: assert property (events_o ==
        {first_irq_o, second_irq_o, third_irq_o})
        else $error("event bundle differs from pulses");
    trig_flag_a: assert property (adc_trigger_o
        |-> third_irq_o && !second_irq_o)
        else $error("trigger without third flag");
    low_step_a: assert property ($changed(capture_base2_o)
        && !$past(wr) |-> capture_base2_o == 16'h0
        || capture_base2_o == $past(capture_base2_o) + 16'h1)
        else $error("low count jumped");
    high_step_a: assert property ($changed(capture_base3_o)
        && !$past(wr) |-> capture_base3_o == 16'h0
        || capture_base3_o == $past(capture_base3_o) + 16'h1)
        else $error("high count jumped");
endmodule
bind stp_timers stp_chk u_chk (.*);

// ---- tb/test_stp_timers.sv ----
// Purpose: self-checking bench for the three-timer block
// Assumes: zero-wait apb, 100 ns clock
// Notes: intervals are timed from pulse to pulse
`timescale 1ns/1ps
module test_stp_timers;
    import stp_pkg::*;
    logic clk_i = 0, rst_i = 1, ce_i = 1, idle_i = 0, g1 = 0;
    logic psel = 0, penable = 0, pwrite = 0, xen = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, a;
    logic pready, pslverr, er, i1, i2, i3, trig, x2;
    logic [3:0] half = 4'h1;
    logic [15:0] cb2, cb3;
    stp_evt_t ev;
    int n_fail = 0, compares = 0, n, k, p;
    wire logic [2:0] iv = {i3, i2, i1};
    logic [7:0] co [3] = '{OFS_CON1, OFS_CON2, OFS_CON3};
    logic [15:0] mk [3] = '{CON1_MASK, CON2_MASK, CON3_MASK};
    stp_timers dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .idle_i(idle_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_ext_clock_pin_i(1'b0), .second_ext_clock_pin_i(x2),
        .third_ext_clock_pin_i(1'b0), .first_gate_i(g1),
        .second_gate_i(1'b0), .third_gate_i(1'b0),
        .first_irq_o(i1), .second_irq_o(i2), .third_irq_o(i3),
        .adc_trigger_o(trig), .capture_base2_o(cb2),
        .capture_base3_o(cb3), .events_o(ev));
    stp_pin_model pins (.clk_i(clk_i), .en_i(xen), .half_i(half),
        .pin_o(x2));
    // free-running bench clock
    initial forever #50 clk_i = ~clk_i;
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] ad,
            input logic [31:0] d);
        int j;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, ad};
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        j = 0;
        do begin
            @(posedge clk_i);
            j++;
        end while (pready !== 1'b1 && j < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (j >= 50) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic wt(input int b, input int lim, output int c);
        c = 0;
        while (iv[b] !== 1'b1 && c < lim) begin
            @(posedge clk_i);
            c++;
        end
    endtask
    task automatic meas(input int b, output int c);
        wt(b, 20000, k);
        @(posedge clk_i);
        wt(b, 20000, c);
        c++;
        if (k >= 20000 || c > 20000) begin
            n_fail++;
            stop_test();
        end
    endtask
    function automatic logic [31:0] per(input int q, s, m);
        return (q + 1) * m * (s == 3 ? 256 : s == 2 ? 64 : s == 1 ? 8 : 1);
    endfunction
    initial begin
        n = $urandom(32'h41b4);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(0, co[i], 0);
            chk("control reset", 0, rd);
            apb(0, co[i] + 8'h08, 0);
            chk("period reset", {16'h0, PER_RESET}, rd);
            apb(1, co[i], 32'hffff7fff);
            apb(0, co[i], 0);
            chk("control bits", {16'h0, mk[i] & 16'h7fff}, rd);
            apb(1, co[i], 0);
        end
        apb(0, 8'h28, 0);
        chk("unmapped error", 1, er);
        for (int s = 0; s < 4; s++) begin
            p = $urandom % 4 + 1;
            apb(1, OFS_PER1, p);
            apb(1, OFS_CNT1, 0);
            apb(1, OFS_CON1, 32'h8000 | (s << 4));
            meas(0, n);
            chk("prescaled interval", per(p, s, 1), n);
            apb(1, OFS_CON1, 0);
        end
        apb(1, OFS_PER1, 32'hffff);
        apb(1, OFS_CON1, 32'ha000);
        idle_i <= 1'b1;
        apb(0, OFS_CNT1, 0);
        a = rd;
        apb(0, OFS_CNT1, 0);
        chk("idle halted", a, rd);
        apb(1, OFS_CON1, 32'h8000);
        apb(0, OFS_CNT1, 0);
        chk("idle running", 1, rd != a);
        idle_i <= 1'b0;
        apb(1, OFS_CON1, 32'h8040);
        g1 <= 1'b1;
        repeat (8) @(posedge clk_i);
        g1 <= 1'b0;
        wt(0, 12, k);
        chk("gate fall pulse", 1, k < 12);
        apb(0, OFS_CNT1, 0);
        a = rd;
        apb(0, OFS_CNT1, 0);
        chk("gate closed", a, rd);
        apb(1, OFS_CON1, 0);
        half <= 4'($urandom % 3 + 1);
        p = $urandom % 3 + 1;
        xen <= 1'b1;
        apb(1, OFS_PER2, p);
        apb(1, OFS_CON2, 32'h8002);
        meas(1, n);
        chk("pin interval", per(p, 0, 2 * (half + 1)), n);
        xen <= 1'b0;
        apb(1, OFS_CON2, 0);
        apb(1, OFS_PER3, 0);
        apb(1, OFS_CON2, 32'h8008);
        meas(2, n);
        chk("paired interval", per(p, 0, 1), n);
        apb(1, OFS_CON2, 32'h0008);
        apb(1, OFS_PER3, 1);
        apb(1, OFS_PER2, 0);
        apb(1, OFS_CNT3, 0);
        apb(1, OFS_CNT2, 32'hfffd);
        apb(1, OFS_CON2, 32'h8008);
        wt(2, 20, k);
        chk("carry match", 1, k < 20);
        apb(0, OFS_CNT3, 0);
        chk("high word cleared", 0, rd);
        apb(0, OFS_FLAG, 0);
        chk("third flag", 1, rd[2]);
        apb(0, OFS_CNT2, 0);
        ce_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        ce_i <= 1'b1;
        stop_test();
    end
endmodule
